// ### sgel_group.sv
// one generic status group: condition, transition filters, event, enable
// assumes a classic wishbone master on the same clock; status inputs are
// synchronous to i_sys_clk
`timescale 1ns/1ps
`include "sgel_consts.svh"

module sgel_group #(
  parameter int WIDTH = `SGEL_WIDTH,
  parameter bit TOP_UNUSED = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_status,
  input wire sgel_pkg::sgel_wb_req_t i_wb_req,
  output sgel_pkg::sgel_wb_rsp_t o_wb_rsp,
  output logic o_summary_ff
);
  import sgel_pkg::*;

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_ff;
  logic rst_b;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_ff[1];

  // ****************************************************************
  // register decode
  // ****************************************************************
  function automatic sgel_reg_t dec_reg(input logic [5:0] adr);
    unique case (adr)
      `SGEL_OFS_COND: dec_reg = SGEL_REG_COND;
      `SGEL_OFS_RISE: dec_reg = SGEL_REG_RISE;
      `SGEL_OFS_FALL: dec_reg = SGEL_REG_FALL;
      `SGEL_OFS_EVENT: dec_reg = SGEL_REG_EVENT;
      `SGEL_OFS_ENABLE: dec_reg = SGEL_REG_ENABLE;
      `SGEL_OFS_CTRL: dec_reg = SGEL_REG_CTRL;
      default: dec_reg = SGEL_REG_NONE;
    endcase
  endfunction

  // mask keeps the unused top bit of a 16-bit group at zero
  localparam logic [WIDTH-1:0] LIVE_MASK =
    (TOP_UNUSED && WIDTH == 16) ? {1'b0, {(WIDTH-1){1'b1}}} : '1;

  sgel_reg_t sel_reg;
  logic req;
  logic wr;
  logic rd;
  logic [WIDTH-1:0] wdat;
  logic [WIDTH-1:0] cond;

  assign sel_reg = dec_reg(i_wb_req.adr);
  // one access per request; ack drops in the cycle after it is given
  assign req = i_wb_req.cyc && i_wb_req.stb && !o_wb_rsp.ack;
  assign wr = req && i_wb_req.we;
  assign rd = req && !i_wb_req.we;
  assign wdat = i_wb_req.dat[WIDTH-1:0];
  assign cond = i_status & LIVE_MASK;

  // write with byte lanes; only full lanes of the group width exist
  function automatic logic [WIDTH-1:0] lane_wr(
    input logic [WIDTH-1:0] old,
    input logic [WIDTH-1:0] nw,
    input logic [3:0] sel
  );
    logic [WIDTH-1:0] r;
    r = old;
    for (int b = 0; b < WIDTH/8; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    lane_wr = r;
  endfunction

  // ****************************************************************
  // host-written filters and enable
  // ****************************************************************
  logic [WIDTH-1:0] rising_edge_filter_ff;
  logic [WIDTH-1:0] falling_edge_filter_ff;
  logic [WIDTH-1:0] enable_ff;

  // clear-status and every query leave these untouched
  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rising_edge_filter_ff <= WIDTH'(`SGEL_RST_RISE);
    end else if (wr && sel_reg == SGEL_REG_RISE) begin
      rising_edge_filter_ff <= lane_wr(rising_edge_filter_ff, wdat,
        i_wb_req.sel) & LIVE_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      falling_edge_filter_ff <= WIDTH'(`SGEL_RST_FILT);
    end else if (wr && sel_reg == SGEL_REG_FALL) begin
      falling_edge_filter_ff <= lane_wr(falling_edge_filter_ff, wdat,
        i_wb_req.sel) & LIVE_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_ff <= WIDTH'(`SGEL_RST_ENABLE);
    end else if (wr && sel_reg == SGEL_REG_ENABLE) begin
      enable_ff <= lane_wr(enable_ff, wdat, i_wb_req.sel) & LIVE_MASK;
    end
  end

  // ****************************************************************
  // transition detection and event latch
  // ****************************************************************
  logic [WIDTH-1:0] cond_prev_ff;
  logic [WIDTH-1:0] event_ff;
  logic [WIDTH-1:0] nxt_event;
  logic [WIDTH-1:0] hit;
  logic clr_event;

  // first sampled value after reset can give an edge: prev starts at zero,
  // so a condition already high at release counts as a rising edge
  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_prev_ff <= '0;
    end else begin
      cond_prev_ff <= cond;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      // each bit gets its own filter pair; none may be omitted
      assign hit[g] =
        (rising_edge_filter_ff[g] && !cond_prev_ff[g] && cond[g]) ||
        (falling_edge_filter_ff[g] && cond_prev_ff[g] && !cond[g]);
    end
  endgenerate
  // both filters set gives either edge, both clear gives none

  assign clr_event = (rd && sel_reg == SGEL_REG_EVENT) ||
    (wr && sel_reg == SGEL_REG_CTRL && i_wb_req.sel[0] &&
     i_wb_req.dat[`SGEL_CTRL_CLS_BIT]);

  // new hits win over a clear in the same cycle; a set bit just stays set
  always_comb begin
    nxt_event = clr_event ? '0 : event_ff;
    nxt_event = nxt_event | hit;
  end

  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_ff <= '0;
    end else begin
      event_ff <= nxt_event & LIVE_MASK;
    end
  end

  // ****************************************************************
  // summary output
  // ****************************************************************
  // summary is registered in the group as one bit; the parent register records it
  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_summary_ff <= 1'b0;
    end else begin
      o_summary_ff <= |(nxt_event & enable_ff);
    end
  end

  // ****************************************************************
  // bus answer
  // ****************************************************************
  logic [31:0] rdat;

  // status is only ever given out on a read, never pushed
  always_comb begin
    rdat = '0;
    unique case (sel_reg)
      SGEL_REG_COND: rdat[WIDTH-1:0] = cond;
      SGEL_REG_RISE: rdat[WIDTH-1:0] = rising_edge_filter_ff;
      SGEL_REG_FALL: rdat[WIDTH-1:0] = falling_edge_filter_ff;
      SGEL_REG_EVENT: rdat[WIDTH-1:0] = event_ff;
      SGEL_REG_ENABLE: rdat[WIDTH-1:0] = enable_ff;
      SGEL_REG_CTRL: rdat = '0;
      SGEL_REG_NONE: rdat = '0;
    endcase
  end

  // all five parts exist even though condition and event are read-only
  always_ff @(posedge i_sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_wb_rsp <= '0;
    end else begin
      o_wb_rsp.ack <= req;
      o_wb_rsp.dat <= rd ? rdat : '0;
    end
  end
endmodule

// ### sgel_consts.svh
// constants for the status group event latch: offsets, fields, resets
// assumes a classic wishbone slave with 32-bit data and byte addresses
//
// Behaviour
// - condition register mirrors live status inputs directly, read-only to host
// - rising filter set and condition goes 0 to 1 sets the event bit
// - falling filter set and condition goes 1 to 0 sets the event bit
// - both filters set: any change of the condition sets the event bit
// - both filters clear: no change of the condition ever sets the event bit
// - filters are host read-write and survive clear-status and any query
// - event bit stays set until the event query or clear-status clears it
// - no counting or queueing: a set event bit ignores further transitions
// - event register is read-only; changed only by transitions and clearing
// - summary is OR over all bits of event AND enable
// - summary leaves the group as one bit for a higher summary register
// - enable is host read-write; clear-status and enable reads leave it alone
// - every group holds condition, both filters, event and enable
// - every group gives the host read and write access to its enable
// - device reports only when read; no notification of its own accord
// - in 16-bit groups the top bit is unused and always reads zero
`ifndef SGEL_CONSTS_SVH
`define SGEL_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define SGEL_OFS_COND 6'h00
`define SGEL_OFS_RISE 6'h04
`define SGEL_OFS_FALL 6'h08
`define SGEL_OFS_EVENT 6'h0c
`define SGEL_OFS_ENABLE 6'h10
`define SGEL_OFS_CTRL 6'h14

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SGEL_CTRL_CLS_BIT 0
`define SGEL_WIDTH 16
`define SGEL_RST_FILT 16'h0000
`define SGEL_RST_RISE 16'h7fff
`define SGEL_RST_ENABLE 16'h0000

`endif

// ### sgel_pkg.sv
// types of the status group event latch
// assumes sgel_consts.svh is on the include path
`include "sgel_consts.svh"

package sgel_pkg;
  typedef logic [`SGEL_WIDTH-1:0] sgel_vec_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [5:0] adr;
    logic [31:0] dat;
  } sgel_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sgel_wb_rsp_t;

  typedef enum logic [2:0] {
    SGEL_REG_COND,
    SGEL_REG_RISE,
    SGEL_REG_FALL,
    SGEL_REG_EVENT,
    SGEL_REG_ENABLE,
    SGEL_REG_CTRL,
    SGEL_REG_NONE
  } sgel_reg_t;
endpackage

// ### sgel_mon_monitor.sv
// checker watching the ports of one status group
// assumes a 16-bit group bound from the bench top file
`timescale 1ns/1ps
module sgel_mon #(
  parameter int WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_status,
  input wire sgel_pkg::sgel_wb_req_t i_wb_req,
  input wire sgel_pkg::sgel_wb_rsp_t o_wb_rsp,
  input wire logic o_summary_ff
);
  import sgel_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wire logic rq = i_wb_req.cyc && i_wb_req.stb;
  wire logic crd = rq && !i_wb_req.we && i_wb_req.adr == 6'h00;
  wire logic ack = o_wb_rsp.ack;
  // ****
  // properties
  // ****
  property p_ack_cause; $rose(ack) |-> $past(rq); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_ack_time; rq && !ack |=> ack; endproperty
  a_ack_time: assert property (p_ack_time) else $error("late ack");
  property p_ack_one; ack |=> !ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  property p_dat_idle; !ack |-> o_wb_rsp.dat == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("idle data");
  property p_top_zero; ack |-> o_wb_rsp.dat[31:15] == 17'h0; endproperty
  a_top_zero: assert property (p_top_zero) else $error("top bit");
  property p_cond_live;
    ack && $past(crd) |-> o_wb_rsp.dat[14:0] == $past(i_status[14:0]);
  endproperty
  a_cond_live: assert property (p_cond_live) else $error("cond read");
  // a falling summary needs a clear or an enable write just before
  property p_sum_fall; $fell(o_summary_ff) |-> $past(rq) || $past(rq, 2);
  endproperty
  a_sum_fall: assert property (p_sum_fall) else $error("sum fell");
  property p_sum_rise;
    $rose(o_summary_ff) |-> $past(i_status) != $past(i_status, 2) ||
      $past(rq, 2);
  endproperty
  a_sum_rise: assert property (p_sum_rise) else $error("sum rose");
  c_sum: cover property ($rose(o_summary_ff));
  c_crd: cover property (ack && $past(crd));
  c_fall: cover property ($fell(o_summary_ff));
endmodule

// ### sgel_host.sv
// polling host: one classic wishbone master
// assumes xfer is entered right after a rising edge
`timescale 1ns/1ps
module sgel_host (
  input wire logic i_sys_clk,
  input wire sgel_pkg::sgel_wb_rsp_t i_rsp,
  output sgel_pkg::sgel_wb_req_t o_req
);
  import sgel_pkg::*;
  initial o_req = '0;
  // ****
  // query, wait for ack, inspect
  // ****
  task automatic xfer(input logic we, input logic [5:0] adr,
    input logic [31:0] wd, input logic [3:0] sel,
    output logic [31:0] rd, output bit ok);
    int n;
    o_req <= '{1'b1, 1'b1, we, sel, adr, wd};
    ok = 0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge i_sys_clk);
      ok = i_rsp.ack;
    end
    rd = i_rsp.dat;
    // released lines show inverted junk, not the old value
    o_req <= '{1'b0, 1'b0, 1'b0, 4'h0, ~adr, ~wd};
    @(posedge i_sys_clk);
  endtask
endmodule

// ### sgel_group_test.sv
// self-checking bench for one 16-bit status group
// assumes sgel_mon and sgel_host compiled before it
`timescale 1ns/1ps
module sgel_group_test;
  import sgel_pkg::*;
  logic i_sys_clk = 0;
  logic i_rst_b = 0;
  sgel_vec_t i_status = '0;
  sgel_wb_req_t req;
  sgel_wb_rsp_t rsp;
  logic sum;
  int errors = 0;
  int comparisons = 0;
  int seed = 32'h75e9;
  int m_ev = 0, m_ri = 'h7fff, m_fa = 0, m_en = 0, m_pv = 0, i;
  bit sn, go;
  int exq[$];
  sgel_group #(.WIDTH(16), .TOP_UNUSED(1'b1)) u_sgel_group (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_status(i_status),
    .i_wb_req(req), .o_wb_rsp(rsp), .o_summary_ff(sum));
  sgel_host u_sgel_host (.i_sys_clk(i_sys_clk), .i_rsp(rsp), .o_req(req));
  initial forever #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk)
    if (go && $random(seed) % 3 == 0) i_status <= 16'($random(seed));
  // ****
  // reference model, one step per edge
  // ****
  always @(posedge i_sys_clk) begin
    int cu, ms, wr, st, a;
    bit tk, cl, ex;
    cu = i_status & 'h7fff;
    a = req.adr;
    ms = {req.sel[1] ? 8'hff : 8'h00, req.sel[0] ? 8'hff : 8'h00};
    wr = req.dat & ms & 'h7fff;
    st = (m_ri & ~m_pv & cu) | (m_fa & m_pv & ~cu);
    tk = req.cyc && req.stb && !sn;
    sn = req.cyc && req.stb;
    if (tk && !req.we) exq.push_back(a == 0 ? cu : a == 4 ? m_ri :
      a == 8 ? m_fa : a == 12 ? m_ev : a == 16 ? m_en : 0);
    cl = tk && (req.we ? a == 20 && req.sel[0] && req.dat[0] : a == 12);
    m_ev = cl ? st : m_ev | st;
    ex = (m_ev & m_en) != 0;
    if (tk && req.we && a == 4) m_ri = m_ri & ~ms | wr;
    if (tk && req.we && a == 8) m_fa = m_fa & ~ms | wr;
    if (tk && req.we && a == 16) m_en = m_en & ~ms | wr;
    m_pv = cu;
    #1 chk_sum(sum, ex);
  end
  task automatic err(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_sum(input logic got, input bit exp);
    comparisons++;
    if (got !== exp) err("summary");
  endtask
  task automatic chk_rd(input logic [31:0] got, input int exp);
    comparisons++;
    if (got !== 32'(exp)) err("read data");
  endtask
  task automatic op(input logic we, input logic [5:0] a,
    input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    bit ok;
    u_sgel_host.xfer(we, a, d, s, rd, ok);
    if (!ok) begin
      err("no ack");
      stop_test();
    end else if (!we) chk_rd(rd, exq.pop_front());
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    go = 1;
    for (i = 0; i < 8; i++) op(1'b0, 6'(i * 4), 32'h0, 4'hf);
    for (i = 0; i < 600; i++)
      op(1'($random(seed)), 6'(($random(seed) & 7) * 4),
        32'($random(seed)), 4'($random(seed)));
    stop_test();
  end
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
endmodule
bind sgel_group sgel_mon #(.WIDTH(WIDTH)) u_sgel_mon (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_status(i_status),
  .i_wb_req(i_wb_req), .o_wb_rsp(o_wb_rsp), .o_summary_ff(o_summary_ff));
